// File: logic/lss_pkg.sv
// Package for the linear array scan sequencer: counts, timing and states.
// Assumes one 10 MHz clock shared by the sensor end and the controller end.
// Functional notes
// - Start high on rising edge begins scan
// - Controller holds start for one clock only
// - 128-stage shift register carries start pulse
// - Freeze edge disconnects samples, starts integrator reset
// - Freeze keeps captured scan unchanged during readout
// - Samples track integrators until freeze
// - Frozen pixels drive output in pixel order
// - Integrators reset 18 clocks, integrate on 19
// - Edge 129 shifts pulse out, output floats
// - Controller always supplies the 129th clock
// - Next start only after charge transfer time
// - Output floats when no output phase runs
// - Chain output marks end of scan
// - At least 20 us between scans
// - Minimum integration is 110 clocks plus transfer
// - Device clock between 5 kHz and 8000 kHz; this package assumes 10 MHz
package lss_pkg;
    localparam int unsigned LSS_PIXELS = 128;
    localparam int unsigned LSS_PIX_W = 8;
    localparam int unsigned LSS_RESET_CLOCKS = 18;
    localparam int unsigned LSS_CLK_PERIOD_NS = 100;
    localparam int unsigned LSS_CHARGE_TRANSFER_US = 20;
    // Least time rounds up to whole cycles
    localparam int unsigned LSS_CHARGE_TRANSFER_CYC =
        (LSS_CHARGE_TRANSFER_US * 1000 + LSS_CLK_PERIOD_NS - 1) / LSS_CLK_PERIOD_NS;
    localparam int unsigned LSS_MIN_INT_CYC = LSS_PIXELS - LSS_RESET_CLOCKS;
    localparam logic [7:0] LSS_RESET_CNT = 8'h12;
    localparam logic [7:0] LSS_LAST_PIX = 8'h7F;
    localparam logic [11:0] LSS_WAIT_CNT = 12'(LSS_CHARGE_TRANSFER_CYC);
    localparam logic [7:0] LSS_PIX_INIT = 8'h00;

    typedef enum logic [1:0] {
        LSS_IDLE = 2'b00,
        LSS_START = 2'b01,
        LSS_READ = 2'b10,
        LSS_WAIT = 2'b11
    } lss_ctl_state_t;
endpackage

// File: logic/lss_link_if.sv
// Interface joining the sensor end and its controller.
// Assumes one common clock; the analog output is modelled as a byte with enable.
`timescale 1ns/1ns
`default_nettype none
interface lss_link_if (
    input wire logic clock
);
    import lss_pkg::*;
    logic start;
    logic freeze;
    logic [LSS_PIX_W-1:0] pixel_level_out;
    logic pixel_level_oe_n;
    logic chain_out;

    modport sensor (
        input start,
        input freeze,
        output pixel_level_out,
        output pixel_level_oe_n,
        output chain_out
    );
    modport ctrl (
        output start,
        output freeze,
        input pixel_level_out,
        input pixel_level_oe_n,
        input chain_out
    );
endinterface
`default_nettype wire

// File: logic/lss_sensor.sv
// Sensor end: shift register sequencer, sample freeze and pixel readout.
// Holds one frozen word per pixel and puts the words on the link in pixel order.
// Assumes start and freeze synchronous to clock; light arrives as pixel_light.
// Assumes the far end supplies the terminating clock of every scan.
`timescale 1ns/1ns
`default_nettype none
module lss_sensor
    import lss_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    lss_link_if.sensor link,
    input wire logic [LSS_PIXELS*LSS_PIX_W-1:0] pixel_light,
    output logic integrating
);
    // Scan position: one stage per pixel, the start pulse is the only set bit
    logic [LSS_PIXELS-1:0] shift_reg;
    logic [LSS_PIXELS-1:0] shift_next;
    logic scan_busy;
    // Frozen pixel words
    logic [LSS_PIX_W-1:0] sample_reg [LSS_PIXELS];
    logic [LSS_PIX_W-1:0] sample_next [LSS_PIXELS];
    logic sample_track;
    // Output stage
    logic [LSS_PIX_W-1:0] out_reg;
    logic [LSS_PIX_W-1:0] out_next;
    logic oe_n_reg;
    logic oe_n_next;
    logic chain_reg;
    logic chain_next;
    // Freeze edge and integrator reset window
    logic freeze_d_reg;
    logic freeze_d_next;
    logic freeze_rise;
    logic [7:0] rst_cnt_reg;
    logic [7:0] rst_cnt_next;
    logic hold_reg;
    logic hold_next;

    // Delayed freeze idles low like the pin, so reset gives no false edge
    always_comb begin
        freeze_d_next = link.freeze;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            freeze_d_reg <= 1'b0;
        end else begin
            freeze_d_reg <= freeze_d_next;
        end
    end

    // rising freeze starts the reset window and freezes samples
    assign freeze_rise = link.freeze & ~freeze_d_reg;

    // start shifts in, one stage per clock
    // Pixel n, counted from one, is on the wire while stage n-1 holds the pulse
    always_comb begin
        shift_next = {shift_reg[LSS_PIXELS-2:0], link.start};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // Any set stage means a readout is under way
    assign scan_busy = |shift_reg;

    // the stage that takes the pulse picks its word; a pixel is
    // driven from its scan edge until the next edge
    always_comb begin
        // no stage set: drive released and level parked at zero
        out_next = '0;
        oe_n_next = 1'b1;
        for (int i = 0; i < LSS_PIXELS; i++) begin
            if (shift_next[i]) begin
                out_next = sample_reg[i];
                oe_n_next = 1'b0;
            end
        end
    end

    // edge 129 pushes the pulse out of the last stage; the chain
    // output repeats it for one clock so a following device can start
    always_comb begin
        chain_next = shift_reg[LSS_PIXELS-1];
    end

    // Output registers, so the wire changes only on clock edges
    always_ff @(posedge clock) begin
        if (rst) begin
            out_reg <= '0;
            oe_n_reg <= 1'b1;
            chain_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
            chain_reg <= chain_next;
        end
    end

    // Integrator reset window counts from the freeze edge
    always_comb begin
        rst_cnt_next = rst_cnt_reg;
        hold_next = hold_reg;
        if (freeze_rise) begin
            rst_cnt_next = LSS_RESET_CNT;
            hold_next = 1'b1;
        end else if (rst_cnt_reg != 8'h00) begin
            rst_cnt_next = rst_cnt_reg - 8'h01;
            if (rst_cnt_reg == 8'h01) begin
                hold_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rst_cnt_reg <= 8'h00;
            hold_reg <= 1'b0;
        end else begin
            rst_cnt_reg <= rst_cnt_next;
            hold_reg <= hold_next;
        end
    end

    // low for the 18 reset clocks, high once integration runs
    assign integrating = (rst_cnt_reg == 8'h00);

    // samples track the integrators only while no readout runs
    // from the freeze edge to the end of the scan they stay put, so light
    // that changes during readout never reaches the wire
    // Limitation: integration restarts on clock 19, but the words on the
    // wire stay those frozen at the start edge until the scan is over
    assign sample_track = !hold_reg && !freeze_rise && !scan_busy;

    generate
        for (genvar g = 0; g < LSS_PIXELS; g++) begin : g_pix
            always_comb begin
                sample_next[g] = sample_reg[g];
                if (sample_track) begin
                    sample_next[g] = pixel_light[g*LSS_PIX_W +: LSS_PIX_W];
                end
            end
            always_ff @(posedge clock) begin
                if (rst) begin
                    sample_reg[g] <= LSS_PIX_INIT;
                end else begin
                    sample_reg[g] <= sample_next[g];
                end
            end
        end
    endgenerate

    // Link outputs come straight from registers
    assign link.pixel_level_out = out_reg;
    assign link.pixel_level_oe_n = oe_n_reg;
    assign link.chain_out = chain_reg;
endmodule
`default_nettype wire

// File: logic/lss_ctrl.sv
// Controller end: issues start pulses and collects 128 pixel levels.
// Assumes the sensor end shares clock and answers per its pixel timing.
`timescale 1ns/1ns
`default_nettype none
module lss_ctrl
    import lss_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    lss_link_if.ctrl link,
    input wire logic scan_req,
    output logic scan_ready,
    output logic pix_valid,
    output logic [6:0] pix_index,
    output logic [LSS_PIX_W-1:0] pix_data,
    output logic scan_done
);
    lss_ctl_state_t state_reg, state_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [11:0] wait_reg, wait_next;
    logic start_reg, start_next;
    logic valid_reg, valid_next;
    logic [6:0] idx_reg, idx_next;
    logic [LSS_PIX_W-1:0] data_reg, data_next;
    logic done_reg, done_next;

    // Scan sequencing
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        wait_next = wait_reg;
        start_next = 1'b0;
        valid_next = 1'b0;
        idx_next = idx_reg;
        data_next = data_reg;
        done_next = 1'b0;
        case (state_reg)
            LSS_IDLE: begin
                if (scan_req) begin
                    start_next = 1'b1;
                    state_next = LSS_START;
                    cnt_next = 8'h00;
                end
            end
            LSS_START: begin
                state_next = LSS_READ;
            end
            LSS_READ: begin
                valid_next = 1'b1;
                idx_next = cnt_reg[6:0];
                data_next = link.pixel_level_out;
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg[6:0] == LSS_LAST_PIX[6:0]) begin
                    state_next = LSS_WAIT;
                    wait_next = LSS_WAIT_CNT;
                    done_next = 1'b1;
                end
            end
            LSS_WAIT: begin
                if (wait_reg == 12'h000) begin
                    state_next = LSS_IDLE;
                end else begin
                    wait_next = wait_reg - 12'h001;
                end
            end
            default: state_next = LSS_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= LSS_IDLE;
            cnt_reg <= 8'h00;
            wait_reg <= 12'h000;
            start_reg <= 1'b0;
            valid_reg <= 1'b0;
            idx_reg <= 7'h00;
            data_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wait_reg <= wait_next;
            start_reg <= start_next;
            valid_reg <= valid_next;
            idx_reg <= idx_next;
            data_reg <= data_next;
            done_reg <= done_next;
        end
    end

    // Freeze tied to start, the usual wiring
    assign link.start = start_reg;
    assign link.freeze = start_reg;
    assign scan_ready = (state_reg == LSS_IDLE);
    assign pix_valid = valid_reg;
    assign pix_index = idx_reg;
    assign pix_data = data_reg;
    assign scan_done = done_reg;
endmodule
`default_nettype wire

// File: verification/lss_link_sva.sv
// Checker for the sensor link: pulse width, drive span, chain and scan spacing.
// Assumes one clock and a synchronous active high reset shared with both ends.
`timescale 1ns/1ns
`default_nettype none
module lss_link_sva
    import lss_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic freeze,
    input wire logic [LSS_PIX_W-1:0] pixel_level_out,
    input wire logic pixel_level_oe_n,
    input wire logic chain_out
);
    logic [7:0] drv_reg;
    logic [7:0] drv_next;
    logic [7:0] gap_reg;
    logic [7:0] gap_next;

    // Drive span and gap since chain; gap saturates so the first scan passes
    always_comb begin
        drv_next = pixel_level_oe_n ? 8'h00 : drv_reg + 8'h01;
        gap_next = chain_out ? 8'h01 : ((gap_reg == 8'hFF) ? gap_reg : gap_reg + 8'h01);
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            drv_reg <= 8'h00;
            gap_reg <= 8'hFF;
        end else begin
            drv_reg <= drv_next;
            gap_reg <= gap_next;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Output floats and the chain pulse lasts one clock
    sequence s_scan_end;
        chain_out && pixel_level_oe_n ##1 !chain_out;
    endsequence

    AST_PULSE: assert property (start |=> !start)
        else $error("start held longer than one clock");
    AST_FIRST: assert property (start |=> !pixel_level_oe_n)
        else $error("pixel output not driven after start");
    AST_END: assert property (start |-> ##129 s_scan_end)
        else $error("scan end not at edge 129");
    AST_SPAN: assert property ($rose(pixel_level_oe_n) |-> drv_reg == 8'h80)
        else $error("drive span not 128 clocks");
    AST_FLOAT: assert property (pixel_level_oe_n |-> pixel_level_out == 8'h00)
        else $error("level not zero while floating");
    AST_QUIET: assert property (pixel_level_oe_n && !start |=> pixel_level_oe_n)
        else $error("output driven without start");
    AST_TIED: assert property (freeze == start)
        else $error("freeze not tied to start");
    AST_SPACE: assert property (start |-> gap_reg >= 8'hC7)
        else $error("start too soon after scan end");
endmodule
`default_nettype wire

// File: verification/test_linear_array_scan_sequencer.sv
// Testbench joining controller end and sensor end; checks collected pixels.
// Assumes package, link interface and both design ends are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_linear_array_scan_sequencer;
    import lss_pkg::*;
    logic clock;
    logic rst;
    logic scan_req;
    logic [LSS_PIXELS*LSS_PIX_W-1:0] pixel_light;
    logic integrating;
    logic scan_ready;
    logic pix_valid;
    logic [6:0] pix_index;
    logic [LSS_PIX_W-1:0] pix_data;
    logic scan_done;
    int fail_count = 0;
    int checks = 0;
    int int_cyc = 0;
    bit chain_seen = 1'b0;

    lss_link_if link (.clock(clock));
    lss_sensor u_lss_sensor (.clock(clock), .rst(rst), .link(link),
        .pixel_light(pixel_light), .integrating(integrating));
    lss_ctrl u_lss_ctrl (.clock(clock), .rst(rst), .link(link), .scan_req(scan_req),
        .scan_ready(scan_ready), .pix_valid(pix_valid), .pix_index(pix_index),
        .pix_data(pix_data), .scan_done(scan_done));
    lss_link_sva u_lss_link_sva (.clock(clock), .rst(rst), .start(link.start),
        .freeze(link.freeze), .pixel_level_out(link.pixel_level_out),
        .pixel_level_oe_n(link.pixel_level_oe_n), .chain_out(link.chain_out));

    // Bench clock, 100 ns period; the logic model has no rate limit
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Clocks with integrators running since the last freeze
    always @(posedge clock) begin
        if (rst || link.freeze) begin
            int_cyc <= 0;
        end else if (integrating) begin
            int_cyc <= int_cyc + 1;
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Light pattern differs per pixel so order slips show up
    task automatic set_light(input logic [7:0] k);
        for (int g = 0; g < LSS_PIXELS; g++) begin
            pixel_light[g*LSS_PIX_W +: LSS_PIX_W] = 8'(g * 3) + k;
        end
    endtask

    // One scan; light changes mid-readout to k_late, which must not show
    task automatic scan(input logic [7:0] k, input logic [7:0] k_late);
        int n;
        int low;
        int drv;
        n = 0;
        low = 0;
        drv = 0;
        for (int t = 0; t < 400 && scan_ready !== 1'b1; t++) begin
            @(posedge clock);
            #5;
        end
        scan_req = 1'b1;
        @(posedge clock);
        #5 scan_req = 1'b0;
        // Only a scan that follows another has a full integration behind it
        if (chain_seen) begin
            check("integration span", 8'h01,
                {7'h00, int_cyc >= LSS_MIN_INT_CYC + LSS_CHARGE_TRANSFER_CYC});
        end
        for (int t = 0; t < 200; t++) begin
            @(posedge clock);
            #5;
            if (integrating === 1'b0) low++;
            if (link.pixel_level_oe_n === 1'b0 && drv == 0) begin
                check("wire pixel 0", 8'(k), link.pixel_level_out);
            end
            if (link.pixel_level_oe_n === 1'b0) drv++;
            if (link.chain_out === 1'b1) begin
                chain_seen = 1'b1;
                check("drive span", 8'h80, 8'(drv));
            end
            if (pix_valid === 1'b1) begin
                check("pix_index", 8'(n), {1'b0, pix_index});
                check("pix_data", 8'(n * 3) + k, pix_data);
                check("scan_done", {7'h00, n == 127}, {7'h00, scan_done});
                n++;
                if (n == 10) set_light(k_late);
            end
        end
        check("pixel count", 8'h80, 8'(n));
        check("reset clocks", 8'h12, 8'(low));
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Two back-to-back scans, the second waits on the transfer gap
    initial begin
        rst = 1'b1;
        scan_req = 1'b0;
        set_light(8'h10);
        repeat (6) @(posedge clock);
        #5 rst = 1'b0;
        check("oe_n idle", 8'h01, {7'h00, link.pixel_level_oe_n});
        scan(8'h10, 8'h5A);
        set_light(8'h33);
        scan(8'h33, 8'hC4);
        tally_and_finish();
    end

    // Watchdog well past two scans and their gaps
    initial begin
        #1000000;
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
